// >>> inc/lxm_pkg.sv
package lxm_pkg;

    // Number of expansion slots that can request mastership; slot 0 wins ties.
    localparam int SLOTS = 5;

    // Legacy address windows; the upper address byte must be zero for a hit.
    localparam logic [7:0] LEG_PAGE = 8'h00;
    localparam logic [23:0] LEG_MEM_LO = 24'h200000;
    localparam logic [23:0] LEG_MEM_HI = 24'h9FFFFF;
    localparam logic [23:0] IO_A_LO = 24'hE80000;
    localparam logic [23:0] IO_A_HI = 24'hEFFFFF;
    localparam logic [23:0] IO_B_LO = 24'hA00000;
    localparam logic [23:0] IO_B_HI = 24'hB7FFFF;
    // Chip-bus memory as seen by a card master.
    localparam logic [23:0] CHIP_MEM_HI = 24'h1FFFFF;

    // Periods of the 7M system clock in one basic legacy cycle.
    localparam logic [3:0] LEG_CYC_TICKS = 4'h4;
    // E clock: high for four 7M periods out of ten.
    localparam logic [3:0] E_HIGH_TICKS = 4'h4;
    localparam logic [3:0] E_PERIOD_TICKS = 4'hA;
    // Synchronisation gap between consecutive legacy cycles, in sys_clk.
    localparam logic [3:0] SYNC_GAP_CYC = 4'h2;

    // Transfer sizes on the local bus.
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // Legacy cycle sequencer states.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_STRB = 5'b00100,
        ST_RLS = 5'b01000,
        ST_GAP = 5'b10000
    } lxm_cyc_t;

endpackage : lxm_pkg

// >>> rtl/lxm_addr_dec.sv
module lxm_addr_dec (
    input wire logic [31:0] addr,
    output logic is_mem,
    output logic is_io,
    output logic is_chip
);
    import lxm_pkg::*;

    logic in_page;
    logic [23:0] low;

    // Only the low 16 megabytes can ever map onto the legacy bus.
    assign in_page = (addr[31:24] == LEG_PAGE);
    assign low = addr[23:0];
    assign is_mem = in_page && (low >= LEG_MEM_LO) && (low <= LEG_MEM_HI);
    assign is_io = in_page && (((low >= IO_A_LO) && (low <= IO_A_HI)) ||
                               ((low >= IO_B_LO) && (low <= IO_B_HI)));
    assign is_chip = in_page && (low <= CHIP_MEM_HI);

endmodule : lxm_addr_dec

// >>> rtl/lxm_arbiter.sv
module lxm_arbiter (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic hold_off,
    input wire logic [lxm_pkg::SLOTS-1:0] req,
    output logic [lxm_pkg::SLOTS-1:0] grant,
    output logic owner_valid
);
    import lxm_pkg::*;

    logic [SLOTS-1:0] grant_q;
    logic [SLOTS-1:0] blocked_q;
    logic [SLOTS-1:0] eligible;
    logic [SLOTS-1:0] pick;
    logic owner_q;
    logic release_now;

    assign grant = grant_q;
    assign owner_valid = owner_q;
    assign release_now = owner_q && ((req & grant_q) == '0);

    // Lowest slot among the requesters not held back wins.
    always_comb begin
        eligible = req & ~blocked_q;
        pick = '0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                pick = '0;
                pick[i] = 1'b1;
            end
        end
    end

    // Grants move only on a 7M edge, so asynchronous requests cannot jam it.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            grant_q <= '0;
            owner_q <= 1'b0;
        end else if (tick) begin
            if (owner_q) begin
                if (release_now) begin
                    grant_q <= '0;
                    owner_q <= 1'b0;
                end
            end else if (!hold_off && (eligible != '0)) begin
                grant_q <= pick;
                owner_q <= 1'b1;
            end
        end
    end

    // A releasing master waits until every other waiting request is served.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            blocked_q <= '0;
        end else if (tick) begin
            if (release_now) begin
                blocked_q <= blocked_q | grant_q;
            end else if (!owner_q && (eligible == '0)) begin
                blocked_q <= '0;
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    property p_hold_off;
        (!owner_q && hold_off) |=> !owner_q;
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("grant during hold");

    property p_keep_owner;
        (owner_q && !release_now) |=> $stable(grant_q) && owner_q;
    endproperty
    a_keep_owner: assert property (p_keep_owner)
        else $error("preempted");

    property p_block_release;
        (tick && release_now) |=> ((blocked_q & $past(grant_q)) != '0);
    endproperty
    a_block_release: assert property (p_block_release)
        else $error("released master not blocked");

    property p_tick_only;
        !tick |=> $stable(grant_q);
    endproperty
    a_tick_only: assert property (p_tick_only)
        else $error("grant off tick");

endmodule : lxm_arbiter

// >>> rtl/lxm_legacy_ctrl.sv
// Operation
// - Bus runs legacy 16-bit mode for legacy cycles and while a card is master, native 32-bit otherwise.
// - Legacy cycles come from a sequencer following the published bus protocol.
// - Memory window is 00200000 through 009FFFFF.
// - I/O windows are 00E80000-00EFFFFF and 00A00000-00B7FFFF.
// - Addresses outside legacy windows never start a legacy cycle.
// - Memory accesses drive cache enable and read both bytes.
// - I/O accesses drive cache disable; read strobes follow requested size.
// - Synchronisation wait states appear as gaps between cycles.
// - Only chip-bus memory answers card masters as a slave.
// - Unsupported card-master accesses flag errors on both buses.
// - Simultaneous requests are granted by fixed slot precedence.
// - The owning master keeps the bus until it lets go.
// - A releasing master waits until later requests are served.
// - No grants while hidden local cycles run.
// - No new cycle starts until the current one fully ends.
// - The E clock is still supplied in legacy mode.
// - A basic cycle lasts four 7M periods, longer with wait states.
module lxm_legacy_ctrl (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic lb_req,
    input wire logic [31:0] lb_addr,
    input wire logic lb_rd,
    input wire logic [1:0] lb_size,
    input wire logic [15:0] lb_wdata,
    output logic lb_ready,
    output logic lb_done,
    output logic [15:0] lb_rdata,
    output logic lb_cache_en,
    output logic lb_cache_dis,
    output logic lb_unclaimed,
    output logic local_berr,
    input wire logic hidden_local_busy,
    output logic chip_req,
    output logic [23:1] chip_addr,
    output logic chip_rd,
    output logic [1:0] chip_be,
    output logic [15:0] chip_wdata,
    input wire logic [15:0] chip_rdata,
    input wire logic chip_ack,
    input wire logic clk7m_pin,
    output logic e_clk,
    output logic mode_native,
    output logic [23:1] exp_addr,
    output logic exp_addr_oe_n,
    output logic exp_as_n,
    output logic exp_uds_n,
    output logic exp_lds_n,
    output logic exp_rw,
    output logic exp_ctl_oe_n,
    input wire logic [15:0] exp_data_in,
    output logic [15:0] exp_data_out,
    output logic exp_data_oe_n,
    input wire logic transfer_ack_n_in,
    output logic transfer_ack_n_out,
    output logic transfer_ack_n_oe_n,
    output logic exp_berr_n_out,
    output logic exp_berr_n_oe_n,
    input wire logic [lxm_pkg::SLOTS-1:0] bus_req_n,
    output logic [lxm_pkg::SLOTS-1:0] bus_grant_n,
    input wire logic [23:1] dma_addr_in,
    input wire logic dma_as_n_in,
    input wire logic dma_uds_n_in,
    input wire logic dma_lds_n_in,
    input wire logic dma_rw_in
);
    import lxm_pkg::*;

    localparam int PW = 50;

    logic [PW-1:0] pin_raw, sync_a_q, sync_b_q;
    logic clk7m_s, clk7m_d_q, tick, ack_s, dma_as_s, dma_uds_s, dma_lds_s;
    logic dma_rw_s;
    logic [SLOTS-1:0] req_s, grant;
    logic [23:1] dma_addr_s;
    logic [15:0] data_s;
    lxm_cyc_t st_q, st_d;
    logic [3:0] cnt_q, gap_q, e_div_q, e_div_d;
    logic e_clk_q, accept, cpu_mem, cpu_io, cpu_hit, arb_owner, hold_off;
    logic rd_q, mem_q, done_q, uncl_q, en_q, dis_q, native_q, ctl_oe_n_q;
    logic as_n_q, uds_n_q, lds_n_q;
    logic [1:0] strobe_q, strobe_d;
    logic [23:1] addr_q;
    logic [15:0] wdata_q, rdata_q, dout_q;
    logic dout_oe_n_q, dma_mem, dma_io, dma_chip, dma_busy_q, dma_go;
    logic chip_req_q, chip_rd_q, ack_drv_q, berr_drv_q, lberr_q;
    logic [1:0] chip_be_q;
    logic [23:1] chip_addr_q;
    logic [15:0] chip_wdata_q;

    // Every pin from the bus passes two flops before any logic looks at it.
    assign pin_raw = {clk7m_pin, transfer_ack_n_in, bus_req_n, dma_as_n_in,
                      dma_uds_n_in, dma_lds_n_in, dma_rw_in, dma_addr_in,
                      exp_data_in};
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync_a_q <= '1;
            sync_b_q <= '1;
        end else begin
            sync_a_q <= pin_raw;
            sync_b_q <= sync_a_q;
        end
    end
    assign {clk7m_s, ack_s, req_s, dma_as_s, dma_uds_s, dma_lds_s, dma_rw_s,
            dma_addr_s, data_s} = sync_b_q;

    // Rising edge of the 7M clock paces both the sequencer and the arbiter.
    // The delay flop resets to the synchroniser's level, so no false edge.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clk7m_d_q <= 1'b1;
        end else begin
            clk7m_d_q <= clk7m_s;
        end
    end
    assign tick = clk7m_s && !clk7m_d_q;

    // The E clock runs from the same divider in every mode.
    always_comb begin
        e_div_d = (e_div_q == E_PERIOD_TICKS - 4'h1) ? 4'h0 : e_div_q + 4'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            e_div_q <= 4'h0;
            e_clk_q <= 1'b0;
        end else if (tick) begin
            e_div_q <= e_div_d;
            e_clk_q <= (e_div_d < E_HIGH_TICKS);
        end
    end
    assign e_clk = e_clk_q;

    lxm_addr_dec u_cpu_dec (
        .addr(lb_addr),
        .is_mem(cpu_mem),
        .is_io(cpu_io),
        .is_chip()
    );
    lxm_addr_dec u_dma_dec (
        .addr({8'h00, dma_addr_s, 1'b0}),
        .is_mem(dma_mem),
        .is_io(dma_io),
        .is_chip(dma_chip)
    );

    // Local requests also hold off grants, closing the race with an accept.
    assign hold_off = hidden_local_busy || (st_q != ST_IDLE) || lb_req;
    lxm_arbiter u_arb (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .tick(tick),
        .hold_off(hold_off),
        .req(~req_s),
        .grant(grant),
        .owner_valid(arb_owner)
    );
    assign bus_grant_n = ~grant;

    assign cpu_hit = cpu_mem || cpu_io;
    assign lb_ready = (st_q == ST_IDLE) && !arb_owner;
    assign accept = lb_req && lb_ready;

    // Memory reads fetch both bytes; otherwise strobes follow the size.
    always_comb begin
        if ((lb_rd && cpu_mem) || (lb_size == SIZE_WORD)) begin
            strobe_d = 2'h3;
        end else begin
            strobe_d = lb_addr[0] ? 2'h1 : 2'h2;
        end
    end

    // Legacy cycle sequencer: address period, strobes, release, sync gap.
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: if (accept && cpu_hit) st_d = ST_ADDR;
            ST_ADDR: if (tick) st_d = ST_STRB;
            ST_STRB: begin
                if (tick && cnt_q >= LEG_CYC_TICKS - 4'h1 && !ack_s) begin
                    st_d = ST_RLS;
                end
            end
            // A card still holding acknowledge stretches the cycle.
            ST_RLS: if (ack_s) st_d = ST_GAP;
            ST_GAP: if (gap_q >= SYNC_GAP_CYC - 4'h1) st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Period and gap counters.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= 4'h0;
            gap_q <= 4'h0;
        end else begin
            if (accept) begin
                cnt_q <= 4'h0;
            end else if (tick && (st_q == ST_ADDR || st_q == ST_STRB)) begin
                cnt_q <= cnt_q + 4'h1;
            end
            gap_q <= (st_q == ST_GAP) ? gap_q + 4'h1 : 4'h0;
        end
    end

    // Latch the request and the cache signals for the whole cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            addr_q <= '0;
            rd_q <= 1'b1;
            mem_q <= 1'b0;
            strobe_q <= 2'h0;
            wdata_q <= '0;
            en_q <= 1'b0;
            dis_q <= 1'b0;
        end else if (st_d == ST_IDLE) begin
            en_q <= 1'b0;
            dis_q <= 1'b0;
        end else if (accept) begin
            addr_q <= lb_addr[23:1];
            rd_q <= lb_rd;
            mem_q <= cpu_mem;
            strobe_q <= strobe_d;
            wdata_q <= lb_wdata;
            en_q <= cpu_mem;
            dis_q <= cpu_io;
        end
    end

    // Bus control pins; the host lets go of them while a card is master.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            as_n_q <= 1'b1;
            uds_n_q <= 1'b1;
            lds_n_q <= 1'b1;
            ctl_oe_n_q <= 1'b1;
            native_q <= 1'b1;
        end else begin
            as_n_q <= (st_d != ST_STRB);
            uds_n_q <= !(st_d == ST_STRB && strobe_q[1]);
            lds_n_q <= !(st_d == ST_STRB && strobe_q[0]);
            ctl_oe_n_q <= (st_d == ST_IDLE) || (st_d == ST_GAP);
            native_q <= (st_d == ST_IDLE) && !arb_owner;
        end
    end

    // Answers to the local bus.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            done_q <= 1'b0;
            uncl_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            done_q <= (st_q == ST_STRB) && (st_d == ST_RLS);
            uncl_q <= accept && !cpu_hit;
            if (st_q == ST_STRB && st_d == ST_RLS && rd_q) begin
                rdata_q <= data_s;
            end
        end
    end

    assign dma_go = arb_owner && !dma_as_s && !dma_busy_q;

    // Card-master access: only chip memory answers; legacy windows get no answer, other addresses a bus error.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dma_busy_q <= 1'b0;
            chip_req_q <= 1'b0;
            chip_addr_q <= '0;
            chip_rd_q <= 1'b1;
            chip_be_q <= 2'h0;
            chip_wdata_q <= '0;
            ack_drv_q <= 1'b0;
            berr_drv_q <= 1'b0;
            lberr_q <= 1'b0;
        end else begin
            lberr_q <= 1'b0;
            if (dma_as_s) begin
                dma_busy_q <= 1'b0;
                chip_req_q <= 1'b0;
                ack_drv_q <= 1'b0;
                berr_drv_q <= 1'b0;
            end else if (dma_go) begin
                dma_busy_q <= 1'b1;
                if (dma_chip) begin
                    chip_req_q <= 1'b1;
                    chip_addr_q <= dma_addr_s;
                    chip_rd_q <= dma_rw_s;
                    chip_be_q <= {!dma_uds_s, !dma_lds_s};
                    chip_wdata_q <= data_s;
                end else if (!(dma_mem || dma_io)) begin
                    berr_drv_q <= 1'b1;
                    lberr_q <= 1'b1;
                end
            end else if (chip_req_q && chip_ack) begin
                chip_req_q <= 1'b0;
                ack_drv_q <= 1'b1;
            end
        end
    end

    // The data pins carry host writes or chip-memory read data to a card.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dout_q <= '0;
            dout_oe_n_q <= 1'b1;
        end else if (chip_req_q && chip_ack && chip_rd_q) begin
            dout_q <= chip_rdata;
            dout_oe_n_q <= 1'b0;
        end else if (st_d == ST_STRB && !rd_q) begin
            dout_q <= wdata_q;
            dout_oe_n_q <= 1'b0;
        end else if (dma_as_s && st_d != ST_STRB) begin
            dout_oe_n_q <= 1'b1;
        end
    end

    assign lb_done = done_q;
    assign lb_rdata = rdata_q;
    assign lb_cache_en = en_q;
    assign lb_cache_dis = dis_q;
    assign lb_unclaimed = uncl_q;
    assign local_berr = lberr_q;
    assign chip_req = chip_req_q;
    assign chip_addr = chip_addr_q;
    assign chip_rd = chip_rd_q;
    assign chip_be = chip_be_q;
    assign chip_wdata = chip_wdata_q;
    assign mode_native = native_q;
    assign exp_addr = addr_q;
    assign exp_addr_oe_n = ctl_oe_n_q;
    assign exp_ctl_oe_n = ctl_oe_n_q;
    assign exp_as_n = as_n_q;
    assign exp_uds_n = uds_n_q;
    assign exp_lds_n = lds_n_q;
    assign exp_rw = rd_q;
    assign exp_data_out = dout_q;
    assign exp_data_oe_n = dout_oe_n_q;
    assign transfer_ack_n_out = 1'b0;
    assign transfer_ack_n_oe_n = !ack_drv_q;
    assign exp_berr_n_out = 1'b0;
    assign exp_berr_n_oe_n = !berr_drv_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_miss;
        accept && !cpu_hit;
    endsequence
    property p_miss;
        s_miss |=> lb_unclaimed && exp_as_n ##1 st_q == ST_IDLE;
    endproperty
    a_miss: assert property (p_miss) else $error("cycle for miss");

    property p_mem_full;
        (st_q == ST_STRB && mem_q && rd_q) |-> lb_cache_en && !lb_cache_dis
            && !exp_uds_n && !exp_lds_n;
    endproperty
    a_mem_full: assert property (p_mem_full) else $error("mem read");

    property p_io_dis;
        (accept && cpu_io) |=> lb_cache_dis && !lb_cache_en;
    endproperty
    a_io_dis: assert property (p_io_dis) else $error("io cache");

    property p_min_len;
        $rose(st_q == ST_RLS) |-> cnt_q >= LEG_CYC_TICKS;
    endproperty
    a_min_len: assert property (p_min_len) else $error("cycle short");

    sequence s_end;
        lb_done;
    endsequence
    property p_gap;
        s_end |-> !lb_ready [*3];
    endproperty
    a_gap: assert property (p_gap) else $error("no gap");

    property p_release;
        (st_q == ST_RLS && !ack_s) |=> !lb_ready;
    endproperty
    a_release: assert property (p_release) else $error("early start");

    property p_berr;
        (dma_go && !dma_chip && !dma_mem && !dma_io) |=>
            local_berr && !exp_berr_n_oe_n ##1 !local_berr;
    endproperty
    a_berr: assert property (p_berr) else $error("no bus error");

    property p_chip_only;
        $rose(chip_req) |-> $past(dma_chip) && arb_owner;
    endproperty
    a_chip_only: assert property (p_chip_only) else $error("bad slave");

    property p_e_clk;
        (tick && e_div_q == E_PERIOD_TICKS - 4'h1) |=> e_clk;
    endproperty
    a_e_clk: assert property (p_e_clk) else $error("E clock");

endmodule : lxm_legacy_ctrl

// >>> verification/lxm_card_model.sv
module lxm_card_model (
    clk7m,
    as_n,
    uds_n,
    lds_n,
    rw,
    addr,
    slow,
    ack_n,
    rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    input wire logic clk7m;
    input wire logic as_n;
    input wire logic uds_n;
    input wire logic lds_n;
    input wire logic rw;
    input wire logic [23:1] addr;
    input wire logic [1:0] slow;
    output logic ack_n;
    output logic [15:0] rdata;
    logic [3:0] cnt;
    logic [15:0] pat;
    logic [15:0] old_q;
    // The card decodes only address and strobes, no peripheral handshake.
    assign pat = {addr[8:1], ~addr[8:1]};
    // Acknowledge after 1+slow 7M edges and let go the moment AS ends.
    always @(posedge clk7m or posedge as_n) begin
        if (as_n) begin
            cnt <= 4'h0;
            ack_n <= 1'b1;
        end else if (!(uds_n && lds_n)) begin
            cnt <= cnt + 4'h1;
            if (cnt >= {2'h0, slow}) ack_n <= 1'b0;
        end
    end
    // A released bus shows the inverse of the last word, so stale data fails.
    always @(posedge as_n) old_q <= pat;
    assign rdata = (!as_n && rw) ? pat : ~old_q;
endmodule : lxm_card_model

// >>> verification/lxm_legacy_ctrl_tb_top.sv
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    n_errors++; $display("Error %0t got %0h exp %0h", $time, g, e); end end
module lxm_legacy_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lxm_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, clk7m_pin = 1'b0, card_ack;
    logic lb_req, lb_rd, hidden_local_busy, chip_ack, dma_as_n_in;
    logic dma_uds_n_in, dma_lds_n_in, dma_rw_in, lb_ready, lb_done;
    logic lb_cache_en, lb_cache_dis, lb_unclaimed, local_berr, chip_req;
    logic chip_rd, e_clk, mode_native, exp_addr_oe_n, exp_as_n, exp_uds_n;
    logic exp_lds_n, exp_rw, exp_ctl_oe_n, exp_data_oe_n, transfer_ack_n_in;
    logic transfer_ack_n_out, transfer_ack_n_oe_n, exp_berr_n_out;
    logic exp_berr_n_oe_n;
    logic [31:0] lb_addr;
    logic [1:0] lb_size, slow, chip_be;
    logic [15:0] lb_wdata, chip_rdata, card_d, exp_data_in, exp_data_out;
    logic [15:0] lb_rdata, chip_wdata;
    logic [23:1] dma_addr_in, chip_addr, exp_addr;
    logic [SLOTS-1:0] bus_req_n, bus_grant_n;
    int n_errors = 0, total_checks = 0, n7 = 0, e_rises = 0;
    logic [31:0] ta [11] = '{32'h00200000, 32'h009FFFFF, 32'h00A00000,
        32'h00B7FFFF, 32'h00E80000, 32'h00EFFFFE, 32'h00500001,
        32'h001FFFFF, 32'h00B80000, 32'h00F00000, 32'h01200000};
    logic [2:0] tm [11] = '{3'h5, 3'h5, 3'h5, 3'h5, 3'h2, 3'h6, 3'h1,
        3'h6, 3'h6, 3'h2, 3'h6};
    logic [31:0] r;

    lxm_legacy_ctrl i_lxm_legacy_ctrl (.sys_clk, .sys_rst, .lb_req, .lb_addr,
        .lb_rd, .lb_size, .lb_wdata, .lb_ready, .lb_done, .lb_rdata,
        .lb_cache_en, .lb_cache_dis, .lb_unclaimed, .local_berr,
        .hidden_local_busy, .chip_req, .chip_addr, .chip_rd, .chip_be,
        .chip_wdata, .chip_rdata, .chip_ack, .clk7m_pin, .e_clk, .mode_native,
        .exp_addr, .exp_addr_oe_n, .exp_as_n, .exp_uds_n, .exp_lds_n, .exp_rw,
        .exp_ctl_oe_n, .exp_data_in, .exp_data_out, .exp_data_oe_n,
        .transfer_ack_n_in, .transfer_ack_n_out, .transfer_ack_n_oe_n,
        .exp_berr_n_out, .exp_berr_n_oe_n, .bus_req_n, .bus_grant_n,
        .dma_addr_in, .dma_as_n_in, .dma_uds_n_in, .dma_lds_n_in, .dma_rw_in);
    lxm_card_model i_lxm_card_model (.clk7m(clk7m_pin), .as_n(exp_as_n),
        .uds_n(exp_uds_n), .lds_n(exp_lds_n), .rw(exp_rw), .addr(exp_addr),
        .slow(slow), .ack_n(card_ack), .rdata(card_d));

    // Shared wires: acknowledge is open drain, data goes to whoever drives.
    assign transfer_ack_n_in = card_ack & (transfer_ack_n_oe_n
        | transfer_ack_n_out);
    assign exp_data_in = exp_data_oe_n ? card_d : exp_data_out;
    // The 7M pin runs free at one fourteenth of the system clock, its edges on falling sys_clk edges.
    always #5 sys_clk = ~sys_clk;
    always #70 clk7m_pin = ~clk7m_pin;
    always @(posedge clk7m_pin) n7++;
    always @(posedge e_clk) e_rises++;

    task automatic end_of_test();
        $display("Checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // One local access, checked against the window map worked out here.
    task automatic lb_access(input logic [31:0] a, input logic [2:0] md);
        int cls, n, e7;
        logic [15:0] wd, m, wq, pat;
        logic [1:0] sb, es;
        logic rw, mn;
        logic [3:0] ex;
        cls = (a >= 32'h00200000 && a <= 32'h009FFFFF) ? 1 :
            ((a >= 32'h00A00000 && a <= 32'h00B7FFFF) ||
            (a >= 32'h00E80000 && a <= 32'h00EFFFFF)) ? 2 : 0;
        wd = 16'($urandom);
        pat = {a[8:1], ~a[8:1]};
        es = (md[1:0] == SIZE_WORD || (cls == 1 && md[2])) ? 2'b00 :
            a[0] ? 2'b10 : 2'b01;
        if (cls == 0) es = 2'b11;
        m = {{8{!es[1]}}, {8{!es[0]}}};
        sb = 2'b11;
        wq = ~wd;
        @(posedge sys_clk);
        {lb_req, lb_addr, lb_rd, lb_size, lb_wdata} <= {1'b1, a, md, wd};
        slow <= 2'($urandom);
        do @(negedge sys_clk); while (!lb_ready);
        @(posedge sys_clk);
        lb_req <= 1'b0;
        e7 = n7;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
            if (!exp_as_n && sb == 2'b11) begin
                {sb, rw, mn} = {exp_uds_n, exp_lds_n, exp_rw,
                    mode_native | exp_ctl_oe_n | exp_addr_oe_n};
                e7 = n7;
            end
            if (!card_ack && !exp_data_oe_n) wq = exp_data_out;
        end while (!lb_done && !lb_unclaimed && n < 3000);
        `CHK(lb_unclaimed, cls == 0)
        `CHK(sb, es)
        if (cls != 0) begin
            ex = {cls == 1, cls == 2, 1'b0, md[2]};
            `CHK({lb_cache_en, lb_cache_dis, mn, rw}, ex)
            `CHK(lb_done, 1'b1)
            `CHK(n7 - e7 >= int'(LEG_CYC_TICKS) - 1, 1'b1)
            if (md[2]) `CHK(lb_rdata & m, pat & m)
            else `CHK(wq & m, wd & m)
            repeat (2) begin
                @(negedge sys_clk);
                `CHK(lb_ready, 1'b0)
            end
        end else `CHK(n, 1)
    endtask : lb_access

    // Set the request pins and expect a grant that then stays put.
    task automatic req(input logic [SLOTS-1:0] rq, input logic [SLOTS-1:0] g);
        int n;
        @(posedge sys_clk);
        bus_req_n <= ~rq;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (bus_grant_n !== ~g && n < 300);
        repeat (40) @(negedge sys_clk);
        `CHK(bus_grant_n, ~g)
    endtask : req

    // Card master read: 0 chip memory, 1 unsupported, 2 legacy space.
    task automatic dma(input logic [23:0] a, input int kind);
        int n;
        logic [15:0] cd;
        logic [2:0] ex;
        cd = 16'($urandom);
        @(posedge sys_clk);
        {dma_addr_in, dma_rw_in, dma_as_n_in, dma_uds_n_in, dma_lds_n_in}
            <= {a[23:1], 4'h8};
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (!chip_req && exp_berr_n_oe_n && n < 100);
        ex = (kind == 0) ? 3'h4 : (kind == 1) ? 3'h3 : 3'h0;
        `CHK({chip_req, !exp_berr_n_oe_n, local_berr}, ex)
        if (kind == 0) begin
            `CHK({chip_rd, chip_be, chip_addr}, {3'h7, a[23:1]})
            @(posedge sys_clk);
            {chip_ack, chip_rdata} <= {1'b1, cd};
            @(posedge sys_clk);
            chip_ack <= 1'b0;
            n = 0;
            do begin
                @(negedge sys_clk);
                n++;
            end while (transfer_ack_n_oe_n && n < 20);
            `CHK({transfer_ack_n_oe_n, exp_data_out}, {1'b0, cd})
        end
        @(posedge sys_clk);
        dma_as_n_in <= 1'b1;
        repeat (20) @(negedge sys_clk);
        `CHK({transfer_ack_n_oe_n, exp_berr_n_oe_n}, 2'b11)
    endtask : dma

    // Main sequence: reset, local windows, arbitration, card master.
    initial begin
        void'($urandom(32'hC2CA7B73));
        {lb_req, lb_rd, hidden_local_busy, chip_ack, lb_addr, lb_size} = '0;
        {lb_wdata, chip_rdata, dma_addr_in, slow} = '0;
        {dma_as_n_in, dma_uds_n_in, dma_lds_n_in, dma_rw_in, bus_req_n} = '1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        `CHK({bus_grant_n, exp_as_n, mode_native}, 7'h7F)
        foreach (ta[i]) lb_access(ta[i], tm[i]);
        for (int i = 0; i < 6; i++) begin
            r = $urandom;
            lb_access({8'h00, r[23:1], r[24] & r[25]},
                {r[26], r[24] ? SIZE_BYTE : SIZE_WORD});
        end
        `CHK(e_rises > 0, 1'b1)
        req(5'h14, 5'h04);
        req(5'h15, 5'h04);
        req(5'h11, 5'h01);
        req(5'h15, 5'h01);
        req(5'h14, 5'h10);
        req(5'h04, 5'h04);
        @(posedge sys_clk);
        hidden_local_busy <= 1'b1;
        req(5'h08, 5'h00);
        @(posedge sys_clk);
        hidden_local_busy <= 1'b0;
        req(5'h08, 5'h08);
        dma(24'h012344, 0);
        dma(24'hC00000, 1);
        dma(24'h200000, 2);
        req(5'h00, 5'h00);
        end_of_test();
    end

    // Watchdog well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        end_of_test();
    end
endmodule : lxm_legacy_ctrl_tb_top
